// ==== common/pmic_regs_pkg.sv ====
// Shared offsets, codes, masks, reset images and timing for the register bank
package pmic_regs_pkg;

    // Timing: a block burn or key store lasts 200 ms at the 20 MHz clock
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BURN_TIME_MS = 200;
    localparam int unsigned BURN_CYCLES =
        int'(64'(BURN_TIME_MS) * 64'(CLK_HZ) / 64'd1000);

    // Offsets
    localparam logic [7:0] OFS_ERR_LOG = 8'h04;
    localparam logic [7:0] OFS_FAULT_LOG = 8'h05;
    localparam logic [7:0] OFS_LOCKOUT_LOG = 8'h06;
    localparam logic [7:0] OFS_LIVE0 = 8'h08;
    localparam logic [7:0] OFS_LIVE3 = 8'h0b;
    localparam logic [7:0] OFS_LOAD_A = 8'h0c;
    localparam logic [7:0] OFS_LOAD_B = 8'h0e;
    localparam logic [7:0] OFS_LOAD_C = 8'h0f;
    localparam logic [7:0] OFS_CLR0 = 8'h10;
    localparam logic [7:0] OFS_CLR4 = 8'h14;
    localparam logic [7:0] OFS_RESTRICT_LO = 8'h15;
    localparam logic [7:0] OFS_DEV_CFG = 8'h2f;
    localparam logic [7:0] OFS_CONV_RES = 8'h31;
    localparam logic [7:0] OFS_ENABLE_SEL = 8'h32;
    localparam logic [7:0] OFS_LIVE4 = 8'h33;
    localparam logic [7:0] OFS_LINK_CFG = 8'h34;
    localparam logic [7:0] OFS_ERR_INJECT = 8'h35;
    localparam logic [7:0] OFS_KEY_LO = 8'h37;
    localparam logic [7:0] OFS_KEY_HI = 8'h38;
    localparam logic [7:0] OFS_VCTRL = 8'h39;
    localparam logic [7:0] OFS_VEND_FIRST = 8'h40;
    localparam logic [7:0] OFS_VEND_LAST = 8'h6f;

    // Field positions
    localparam int unsigned WP_BIT = 2;
    localparam int unsigned CLR_ALL_BIT = 0;

    // Vendor region control codes
    localparam logic [7:0] CMD_LOCK = 8'h00;
    localparam logic [7:0] CMD_UNLOCK = 8'h40;
    localparam logic [7:0] CMD_NEW_KEY = 8'h80;
    localparam logic [7:0] CMD_BURN_40 = 8'h81;
    localparam logic [7:0] CMD_BURN_50 = 8'h82;
    localparam logic [7:0] CMD_BURN_60 = 8'h85;
    localparam logic [7:0] CODE_DONE = 8'h5a;
    localparam logic [1:0] KIND_KEY = 2'h3;
    localparam logic [15:0] FACTORY_KEY = 16'h9473;

    // Readable bits of read-only and live status bytes, writable bits of link config
    localparam logic [7:0] ERR_LOG_MASK = 8'hf0;
    localparam logic [7:0] FAULT_LOG_MASK = 8'h5f;
    localparam logic [7:0] LOCKOUT_MASK = 8'hbb;
    localparam logic [39:0] LIVE_MASK = {8'hec, 8'hbb, 8'hbe, 8'hab, 8'h6d};
    localparam logic [7:0] LINK_CFG_WMASK = 8'he0;

    // Programming states, one bit flips per step except DONE back to IDLE
    typedef enum logic [1:0] {
        NVM_IDLE = 2'h0,
        NVM_PROG = 2'h1,
        NVM_DONE = 2'h3
    } nvm_state_t;

    // Host register {reset, readable mask}; zero mask means not stored
    function automatic logic [15:0] host_attr(input logic [5:0] i);
        case (i)
            6'h15: host_attr = {8'h2c, 8'h2d};
            6'h16: host_attr = {8'h20, 8'hab};
            6'h17: host_attr = {8'h00, 8'hbc};
            6'h18: host_attr = {8'h00, 8'hbb};
            6'h19: host_attr = {8'h04, 8'h0c};
            6'h1b: host_attr = {8'h05, 8'hdf};
            6'h1c, 6'h1e: host_attr = {8'h30, 8'hff};
            6'h1f: host_attr = {8'h10, 8'hff};
            6'h20: host_attr = {8'hcf, 8'hff};
            6'h21, 6'h25, 6'h27: host_attr = {8'h78, 8'hff};
            6'h22, 6'h26, 6'h28: host_attr = {8'h63, 8'hff};
            6'h29: host_attr = {8'h80, 8'hff};
            6'h2a: host_attr = {8'h88, 8'hff};
            6'h2b: host_attr = {8'h42, 8'hff};
            6'h2c: host_attr = {8'h20, 8'hff};
            6'h2d: host_attr = {8'h22, 8'hff};
            6'h2f: host_attr = {8'h02, 8'h5f};
            6'h30: host_attr = {8'h00, 8'hff};
            6'h32: host_attr = {8'h00, 8'hf3};
            6'h34: host_attr = {8'h0e, 8'hee};
            6'h3a: host_attr = {8'h00, 8'h7e};
            default: host_attr = 16'h0000;
        endcase
    endfunction

    function automatic logic [63:0][7:0] host_reset_image();
        for (int i = 0; i < 64; i++) begin
            host_reset_image[i] = 8'(host_attr(6'(i)) >> 8);
        end
    endfunction

    // Factory contents of the vendor region, index is offset minus 0x40
    function automatic logic [47:0][7:0] vendor_factory_image();
        vendor_factory_image = '0;
        for (int i = 0; i < 48; i++) begin
            case (i)
                0: vendor_factory_image[i] = 8'h89;
                1, 25: vendor_factory_image[i] = 8'hd9;
                5, 9, 11: vendor_factory_image[i] = 8'h78;
                6, 10, 12: vendor_factory_image[i] = 8'h63;
                13: vendor_factory_image[i] = 8'h80;
                14: vendor_factory_image[i] = 8'h88;
                16: vendor_factory_image[i] = 8'hcf;
                17: vendor_factory_image[i] = 8'h42;
                24: vendor_factory_image[i] = 8'hd1;
                29: vendor_factory_image[i] = 8'h20;
                30: vendor_factory_image[i] = 8'h22;
                default: vendor_factory_image[i] = 8'h00;
            endcase
        end
    endfunction

    localparam logic [63:0][7:0] HOST_RESET = host_reset_image();
    localparam logic [47:0][7:0] VENDOR_FACTORY = vendor_factory_image();

endpackage

// ==== logic/nvm_store.sv ====
// Non-volatile store of the vendor region and key, with timed programming
`timescale 1ns/1ps
module nvm_store #(
    parameter int unsigned BURN_CYCLES = pmic_regs_pkg::BURN_CYCLES
) (
    // Clock and first-power reset
    input wire logic clk_sys,
    input wire logic factory_rst_b,
    // Programming request
    input wire logic prog_req,
    input wire logic [1:0] prog_kind,
    input wire logic [47:0][7:0] prog_image,
    input wire logic [15:0] prog_key,
    // Progress
    output logic prog_busy,
    output logic prog_done,
    // Stored contents
    output logic [47:0][7:0] nvm_image,
    output logic [15:0] nvm_key
);

    typedef struct packed {
        pmic_regs_pkg::nvm_state_t state;
        logic [21:0] cnt;
        logic [47:0][7:0] image;
        logic [15:0] key;
    } nvm_reg_t;

    nvm_reg_t q_reg;
    nvm_reg_t q_next;

    // Commit at request, then hold busy for the burn time
    always_comb begin
        q_next = q_reg;
        unique case (q_reg.state)
            pmic_regs_pkg::NVM_IDLE: begin
                if (prog_req) begin
                    if (prog_kind == pmic_regs_pkg::KIND_KEY) begin
                        q_next.key = prog_key;
                    end else begin
                        // Only the chosen 16-byte block is touched
                        q_next.image[{prog_kind, 4'h0} +: 16] =
                            prog_image[{prog_kind, 4'h0} +: 16];
                    end
                    q_next.cnt = '0;
                    q_next.state = pmic_regs_pkg::NVM_PROG;
                end
            end
            pmic_regs_pkg::NVM_PROG: begin
                if (q_reg.cnt == 22'(BURN_CYCLES - 1)) begin
                    q_next.state = pmic_regs_pkg::NVM_DONE;
                end else begin
                    q_next.cnt = q_reg.cnt + 22'h1;
                end
            end
            pmic_regs_pkg::NVM_DONE: q_next.state = pmic_regs_pkg::NVM_IDLE;
            default: q_next.state = pmic_regs_pkg::NVM_IDLE;
        endcase
    end

    // Only the first-ever power-up resets the store; supply loss keeps it
    always_ff @(posedge clk_sys or negedge factory_rst_b) begin
        if (!factory_rst_b) begin
            q_reg <= '{state: pmic_regs_pkg::NVM_IDLE, cnt: '0,
                image: pmic_regs_pkg::VENDOR_FACTORY,
                key: pmic_regs_pkg::FACTORY_KEY};
        end else begin
            q_reg <= q_next;
        end
    end

    assign prog_busy = (q_reg.state != pmic_regs_pkg::NVM_IDLE);
    assign prog_done = (q_reg.state == pmic_regs_pkg::NVM_DONE);
    assign nvm_image = q_reg.image;
    assign nvm_key = q_reg.key;

endmodule

// ==== logic/pmic_reg_bank.sv ====
// Register bank with write protect, vendor key gate and block burn
// Overview of operation
// - Read-only bits read live, ignore writes
// - Write-only key bytes always read zero
// - Reserved bits read zero, ignore writes
// - Set-only bits act on one, zero ignored
// - Persistent contents survive supply removal
// - Guarded bits hidden until key matches
// - Host user registers always writable
// - Restricted ranges frozen in write protect, except the WP bit itself
// - Vendor range blocked until unlocked
// - Factory key 0x9473, vendor may replace
// - New key applies after supply cycle
// - Unlock compares against key loaded at power-up
// - Vendor range burned in three blocks
// - Codes 81/82/85 burn one block
// - Burn ends in 200ms, reads 0x5A
`timescale 1ns/1ps
module pmic_reg_bank #(
    parameter int unsigned BURN_CYCLES = pmic_regs_pkg::BURN_CYCLES
) (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic factory_rst_b,
    // Host register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Logs and telemetry from on-chip logic
    input wire logic [23:0] fault_log,
    input wire logic [23:0] load_measure,
    input wire logic [7:0] conv_result,
    // Raw status events from the analog side
    input wire logic [39:0] status_event,
    // Configuration and state toward the device
    output logic [63:0][7:0] cfg_image,
    output logic [47:0][7:0] vendor_image,
    output logic wp_mode,
    output logic vendor_open,
    output logic nvm_busy
);

    typedef struct packed {
        logic [63:0][7:0] hreg;
        logic [47:0][7:0] vreg;
        logic [4:0][7:0] live;
        logic [39:0] ev_s1;
        logic [39:0] ev_s2;
        logic [7:0] key_lo;
        logic [7:0] key_hi;
        logic [15:0] active_key;
        logic unlocked;
        logic [7:0] ctrl;
        logic loaded;
        logic [7:0] rdata;
        logic prog_req;
        logic [1:0] prog_kind;
    } bank_reg_t;

    bank_reg_t q_reg;
    bank_reg_t q_next;

    logic prog_busy;
    logic prog_done;
    logic [47:0][7:0] nvm_image;
    logic [15:0] nvm_key;

    // Host byte index and region decode
    function automatic logic restricted(input logic [7:0] a);
        restricted = (a >= pmic_regs_pkg::OFS_RESTRICT_LO &&
                      a <= pmic_regs_pkg::OFS_DEV_CFG) ||
                     a == pmic_regs_pkg::OFS_ENABLE_SEL ||
                     a == pmic_regs_pkg::OFS_ERR_INJECT ||
                     a >= pmic_regs_pkg::OFS_VEND_FIRST;
    endfunction

    function automatic logic [7:0] host_rmask(input logic [7:0] a);
        host_rmask = 8'(pmic_regs_pkg::host_attr(a[5:0]));
    endfunction

    // Working nets of the combinational process
    logic wp;
    logic in_vendor;
    logic [5:0] hidx;
    logic [5:0] vidx;
    logic [2:0] cidx;
    logic [7:0] wmask;
    logic [4:0][7:0] clr;
    logic [7:0] rval;
    logic key_ok;
    logic cmd_ok;

    always_comb begin
        q_next = q_reg;
        q_next.prog_req = 1'b0;
        wp = q_reg.hreg[pmic_regs_pkg::OFS_DEV_CFG[5:0]][pmic_regs_pkg::WP_BIT];
        in_vendor = reg_addr >= pmic_regs_pkg::OFS_VEND_FIRST &&
                    reg_addr <= pmic_regs_pkg::OFS_VEND_LAST;
        hidx = reg_addr[5:0];
        vidx = 6'(reg_addr - pmic_regs_pkg::OFS_VEND_FIRST);
        cidx = 3'(reg_addr - pmic_regs_pkg::OFS_CLR0);
        wmask = 8'h00;
        clr = '0;
        rval = 8'h00;
        key_ok = ({q_reg.key_hi, q_reg.key_lo} == q_reg.active_key);
        cmd_ok = q_reg.unlocked && !prog_busy && !q_reg.prog_req;

        // Events come from another domain: two flops before use
        q_next.ev_s1 = status_event;
        q_next.ev_s2 = q_reg.ev_s1;

        // First cycle after power-up: pick up persistent contents
        if (!q_reg.loaded) begin
            q_next.vreg = nvm_image;
            q_next.active_key = nvm_key;
            q_next.loaded = 1'b1;
        end

        // Host writes
        if (reg_wr) begin
            if (reg_addr >= pmic_regs_pkg::OFS_CLR0 &&
                reg_addr <= pmic_regs_pkg::OFS_CLR4) begin
                // Ones clear, zeros leave the latch alone
                clr[cidx] = reg_wdata;
                if (reg_addr == pmic_regs_pkg::OFS_CLR4 &&
                    reg_wdata[pmic_regs_pkg::CLR_ALL_BIT]) begin
                    clr = '1;
                end
            end else if (reg_addr == pmic_regs_pkg::OFS_KEY_LO) begin
                q_next.key_lo = reg_wdata;
            end else if (reg_addr == pmic_regs_pkg::OFS_KEY_HI) begin
                q_next.key_hi = reg_wdata;
            end else if (reg_addr == pmic_regs_pkg::OFS_VCTRL) begin
                case (reg_wdata)
                    pmic_regs_pkg::CMD_LOCK: begin
                        q_next.unlocked = 1'b0;
                        q_next.ctrl = reg_wdata;
                    end
                    pmic_regs_pkg::CMD_UNLOCK: begin
                        // A wrong key leaves the region shut
                        q_next.unlocked = key_ok;
                        q_next.ctrl = reg_wdata;
                    end
                    pmic_regs_pkg::CMD_NEW_KEY: begin
                        if (cmd_ok) begin
                            q_next.prog_req = 1'b1;
                            q_next.prog_kind = pmic_regs_pkg::KIND_KEY;
                            q_next.ctrl = reg_wdata;
                        end
                    end
                    pmic_regs_pkg::CMD_BURN_40: begin
                        if (cmd_ok) begin
                            q_next.prog_req = 1'b1;
                            q_next.prog_kind = 2'h0;
                            q_next.ctrl = reg_wdata;
                        end
                    end
                    pmic_regs_pkg::CMD_BURN_50: begin
                        if (cmd_ok) begin
                            q_next.prog_req = 1'b1;
                            q_next.prog_kind = 2'h1;
                            q_next.ctrl = reg_wdata;
                        end
                    end
                    pmic_regs_pkg::CMD_BURN_60: begin
                        if (cmd_ok) begin
                            q_next.prog_req = 1'b1;
                            q_next.prog_kind = 2'h2;
                            q_next.ctrl = reg_wdata;
                        end
                    end
                    default: begin
                        // Unknown codes are kept but start nothing
                        q_next.ctrl = reg_wdata;
                    end
                endcase
            end else if (reg_addr < pmic_regs_pkg::OFS_VEND_FIRST) begin
                // Read-only and reserved bits are outside the mask
                wmask = host_rmask(reg_addr);
                if (reg_addr == pmic_regs_pkg::OFS_LINK_CFG) begin
                    wmask = pmic_regs_pkg::LINK_CFG_WMASK;
                end
                if (wp && restricted(reg_addr)) begin
                    // Keep the protect bit itself reachable, or WP sticks
                    wmask = (reg_addr == pmic_regs_pkg::OFS_DEV_CFG) ?
                            8'(1 << pmic_regs_pkg::WP_BIT) : 8'h00;
                end
                q_next.hreg[hidx] = (q_reg.hreg[hidx] & ~wmask) |
                                    (reg_wdata & wmask);
            end else if (in_vendor) begin
                if (q_reg.unlocked && !wp) begin
                    q_next.vreg[vidx] = reg_wdata;
                end
            end
        end

        // Latched status: a new event beats a clear in the same cycle
        q_next.live = (q_reg.live & ~clr) |
                      (q_reg.ev_s2 & pmic_regs_pkg::LIVE_MASK);

        // Programming finished: report completion code
        if (prog_done) begin
            q_next.ctrl = pmic_regs_pkg::CODE_DONE;
        end

        // Host reads, answered one cycle later
        if (reg_addr < pmic_regs_pkg::OFS_VEND_FIRST) begin
            case (reg_addr)
                pmic_regs_pkg::OFS_ERR_LOG:
                    rval = fault_log[7:0] & pmic_regs_pkg::ERR_LOG_MASK;
                pmic_regs_pkg::OFS_FAULT_LOG:
                    rval = fault_log[15:8] & pmic_regs_pkg::FAULT_LOG_MASK;
                pmic_regs_pkg::OFS_LOCKOUT_LOG:
                    rval = fault_log[23:16] & pmic_regs_pkg::LOCKOUT_MASK;
                pmic_regs_pkg::OFS_LOAD_A: rval = load_measure[7:0];
                pmic_regs_pkg::OFS_LOAD_B: rval = load_measure[15:8];
                pmic_regs_pkg::OFS_LOAD_C: rval = load_measure[23:16];
                pmic_regs_pkg::OFS_CONV_RES: rval = conv_result;
                pmic_regs_pkg::OFS_LIVE4: rval = q_reg.live[4];
                pmic_regs_pkg::OFS_KEY_LO,
                pmic_regs_pkg::OFS_KEY_HI: rval = 8'h00;
                pmic_regs_pkg::OFS_VCTRL: rval = q_reg.ctrl;
                default: begin
                    if (reg_addr >= pmic_regs_pkg::OFS_LIVE0 &&
                        reg_addr <= pmic_regs_pkg::OFS_LIVE3) begin
                        rval = q_reg.live[reg_addr[1:0]];
                    end else begin
                        // Clear registers and holes have no readable bits
                        rval = q_reg.hreg[hidx] & host_rmask(reg_addr);
                    end
                end
            endcase
        end else if (in_vendor && q_reg.unlocked) begin
            rval = q_reg.vreg[vidx];
        end
        if (reg_rd) begin
            q_next.rdata = rval;
        end
    end

    // Power-on state; vendor copy and key are refreshed from the store
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q_reg <= '{hreg: pmic_regs_pkg::HOST_RESET,
                vreg: pmic_regs_pkg::VENDOR_FACTORY,
                live: '0,
                ev_s1: '0,
                ev_s2: '0,
                key_lo: 8'h00,
                key_hi: 8'h00,
                active_key: pmic_regs_pkg::FACTORY_KEY,
                unlocked: 1'b0,
                ctrl: 8'h00,
                loaded: 1'b0,
                rdata: 8'h00,
                prog_req: 1'b0,
                prog_kind: 2'h0};
        end else begin
            q_reg <= q_next;
        end
    end

    // Persistent store
    nvm_store #(
        .BURN_CYCLES(BURN_CYCLES)
    ) nvm_store_inst (
        .clk_sys(clk_sys),
        .factory_rst_b(factory_rst_b),
        .prog_req(q_reg.prog_req),
        .prog_kind(q_reg.prog_kind),
        .prog_image(q_reg.vreg),
        .prog_key({q_reg.key_hi, q_reg.key_lo}),
        .prog_busy(prog_busy),
        .prog_done(prog_done),
        .nvm_image(nvm_image),
        .nvm_key(nvm_key)
    );

    // Outputs
    assign reg_rdata = q_reg.rdata;
    assign cfg_image = q_reg.hreg;
    assign vendor_image = q_reg.vreg;
    assign wp_mode =
        q_reg.hreg[pmic_regs_pkg::OFS_DEV_CFG[5:0]][pmic_regs_pkg::WP_BIT];
    assign vendor_open = q_reg.unlocked;
    assign nvm_busy = prog_busy;

endmodule

// ==== testbench/host.sv ====
// Host controller model issuing register cycles
`timescale 1ns/1ps
module host (
    // Clock
    input wire logic clk_sys,
    // Register cycles
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle bus from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Write strobe held for exactly one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // Stale data flipped, never mistaken for valid
        #1;
    endtask
    // Read data is registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask
endmodule

// ==== testbench/pmic_reg_bank_checker.sv ====
// Port-level assertions for the register bank
`timescale 1ns/1ps
module pmic_reg_bank_checker #(
    parameter int unsigned BURN_CYCLES = pmic_regs_pkg::BURN_CYCLES
) (
    // Clock, reset and host bus
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Sources and state
    input wire logic [23:0] fault_log,
    input wire logic [63:0][7:0] cfg_image,
    input wire logic wp_mode,
    input wire logic vendor_open,
    input wire logic nvm_busy
);
    int unsigned busy_len;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Length of the current programming run
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_len <= 0;
        end else begin
            busy_len <= nvm_busy ? busy_len + 1 : 0;
        end
    end
    AST_WO_ZERO: assert property (reg_rd && reg_addr inside {8'h37, 8'h38}
        |=> reg_rdata == 8'h00) else $error("key byte read not zero");
    AST_RO_LIVE: assert property (reg_rd && reg_addr == 8'h04
        |=> {16'h0, reg_rdata} == ($past(fault_log) & 24'hf0)) else $error("log read wrong");
    AST_VEND_HIDDEN: assert property (reg_rd && !vendor_open && reg_addr >= 8'h40
        && reg_addr <= 8'h6f |=> reg_rdata == 8'h00) else $error("locked vendor read");
    AST_HIGH_ZERO: assert property (reg_rd && reg_addr >= 8'h70
        |=> reg_rdata == 8'h00) else $error("upper range read not zero");
    AST_WP_FREEZE: assert property (wp_mode && reg_wr && reg_addr == 8'h21
        |=> $stable(cfg_image[33])) else $error("protected register changed");
    AST_USER_WRITE: assert property (reg_wr && reg_addr == 8'h30
        |=> cfg_image[48] == $past(reg_wdata)) else $error("user register not written");
    AST_BURN_START: assert property (reg_wr && reg_addr == 8'h39 && vendor_open && !nvm_busy
        && reg_wdata inside {8'h81, 8'h82, 8'h85} |-> ##2 nvm_busy) else $error("no burn");
    AST_BURN_LEN: assert property ($fell(nvm_busy) |-> busy_len == BURN_CYCLES + 1)
        else $error("burn length wrong");
    // Main scenarios reached
    cover property ($rose(vendor_open));
    cover property ($fell(nvm_busy));
    cover property (wp_mode && reg_wr);
endmodule

// ==== testbench/pmic_reg_bank_tb.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ps
module pmic_reg_bank_tb;
    localparam int unsigned BC = 20;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic factory_rst_b = 1'b0;
    logic [23:0] fault_log = 24'h0;
    logic [39:0] status_event = 40'h0;
    logic reg_wr, reg_rd, wp_mode, vendor_open, nvm_busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got, r0, r1, r2;
    logic [47:0][7:0] vimg;
    logic [7:0] nvm_q [$];
    logic [15:0] rv [6] = '{16'h152c, 16'h1620, 16'h1904, 16'h20cf, 16'h340e, 16'h2f02};
    int err_total = 0;
    int checks = 0;
    int seed = 32'h89ce;
    // Clock and parts
    always #25 clk_sys = ~clk_sys;
    host host_inst (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    pmic_reg_bank #(.BURN_CYCLES(BC)) pmic_reg_bank_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .factory_rst_b(factory_rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fault_log(fault_log),
        .load_measure(fault_log), .conv_result(fault_log[23:16]),
        .status_event(status_event),
        .cfg_image(), .vendor_image(vimg), .wp_mode(wp_mode), .vendor_open(vendor_open),
        .nvm_busy(nvm_busy));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_inst.rd(a, got);
        chk($sformatf("reg %h", a), got, e);
    endtask
    task automatic unlock(input logic [15:0] k);
        host_inst.wr(8'h37, k[7:0]);
        host_inst.wr(8'h38, k[15:8]);
        host_inst.wr(8'h39, 8'h40);
    endtask
    // Command, then poll for completion under a bound
    task automatic burn(input logic [7:0] c);
        int n = 0;
        host_inst.wr(8'h39, c);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("busy", {7'h0, nvm_busy}, 8'h01);
        while (nvm_busy === 1'b1 && n < BC + 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("done", {7'h0, nvm_busy}, 8'h00);
        rchk(8'h39, 8'h5a);
    endtask
    task automatic wrap_up;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        factory_rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        foreach (rv[i])
            rchk(rv[i][15:8], rv[i][7:0]);
        rchk(8'h1d, 8'h00);
        rchk(8'h80, 8'h00);
        @(posedge clk_sys) fault_log <= 24'($random(seed));
        host_inst.wr(8'h04, 8'hf0);
        rchk(8'h04, fault_log[7:0] & pmic_regs_pkg::ERR_LOG_MASK);
        rchk(8'h0e, fault_log[15:8]);
        rchk(8'h31, fault_log[23:16]);
        host_inst.wr(8'h37, 8'h5c);
        rchk(8'h37, 8'h00);
        // Write protect freezes restricted settings only
        r0 = 8'($random(seed));
        host_inst.wr(8'h21, r0);
        host_inst.wr(8'h2f, 8'h06);
        host_inst.wr(8'h21, ~r0);
        host_inst.wr(8'h30, r0);
        rchk(8'h21, r0);
        rchk(8'h30, r0);
        host_inst.wr(8'h2f, 8'h02);
        // Latched status, zero ignored, one clears
        @(posedge clk_sys) status_event <= 40'h05;
        repeat (4) @(posedge clk_sys);
        status_event <= 40'h0;
        host_inst.wr(8'h10, 8'h00);
        rchk(8'h08, 8'h05);
        host_inst.wr(8'h10, 8'h04);
        rchk(8'h08, 8'h01);
        host_inst.wr(8'h14, 8'h01);
        rchk(8'h08, 8'h00);
        // Vendor gate, blocks and key change
        rchk(8'h40, 8'h00);
        host_inst.wr(8'h40, 8'h11);
        unlock(16'h1234);
        chk("open", {7'h0, vendor_open}, 8'h00);
        unlock(16'h9473);
        chk("open", {7'h0, vendor_open}, 8'h01);
        rchk(8'h40, 8'h89);
        r0 = 8'($random(seed));
        r1 = 8'($random(seed));
        r2 = 8'($random(seed));
        host_inst.wr(8'h4f, r0);
        chk("vimg", vimg[15], r0);
        host_inst.wr(8'h50, r1);
        host_inst.wr(8'h60, r2);
        nvm_q = '{r0, r1, r2};
        burn(8'h81);
        burn(8'h82);
        burn(8'h85);
        rchk(8'h4f, r0);
        host_inst.wr(8'h51, r1);
        host_inst.wr(8'h37, 8'hc3);
        host_inst.wr(8'h38, 8'h5e);
        burn(8'h80);
        host_inst.wr(8'h39, 8'h00);
        chk("open", {7'h0, vendor_open}, 8'h00);
        unlock(16'h9473);
        chk("open", {7'h0, vendor_open}, 8'h01);
        // Supply cycle; the store keeps its contents
        @(posedge clk_sys) rst_b <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        unlock(16'h9473);
        chk("open", {7'h0, vendor_open}, 8'h00);
        unlock(16'h5ec3);
        chk("open", {7'h0, vendor_open}, 8'h01);
        rchk(8'h4f, nvm_q.pop_front());
        rchk(8'h50, nvm_q.pop_front());
        rchk(8'h60, nvm_q.pop_front());
        rchk(8'h51, 8'h42);
        wrap_up;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        wrap_up;
    end
endmodule
bind pmic_reg_bank pmic_reg_bank_checker #(.BURN_CYCLES(BURN_CYCLES)) pmic_reg_bank_checker_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fault_log(fault_log),
    .cfg_image(cfg_image), .wp_mode(wp_mode), .vendor_open(vendor_open), .nvm_busy(nvm_busy));
